/* File: core/adcseq_pkg.sv */
/*
  Constants and types shared by the converter sequencer: register offsets,
  field positions, reset values, cycle counts and the sequencer states.
  Assumes a 32-bit APB register bus and a single oscillator clock domain.
*/
package adcseq_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCSEQ_OFS_MAIN = 8'h00;    // Converter main control
  localparam logic [7:0] ADCSEQ_OFS_PIN = 8'h04;     // Analog pin mask
  localparam logic [7:0] ADCSEQ_OFS_TIMING = 8'h08;  // Converter timing control
  localparam logic [7:0] ADCSEQ_OFS_RES_HI = 8'h0c;  // Result high byte
  localparam logic [7:0] ADCSEQ_OFS_RES_LO = 8'h10;  // Result low byte
  localparam logic [7:0] ADCSEQ_OFS_STATUS = 8'h14;  // Done flag, write one to clear
  localparam logic [7:0] ADCSEQ_OFS_COMPARE = 8'h18; // Compare unit mode
  localparam logic [7:0] ADCSEQ_OFS_PORT = 8'h1c;    // Port data read-back

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ADCSEQ_BIT_ON = 0;       // converter_on
  localparam int ADCSEQ_BIT_GO = 1;       // conversion_start_flag
  localparam int ADCSEQ_CHAN_LSB = 2;     // channel_select low bit
  localparam int ADCSEQ_BIT_CAL = 7;      // offset_calibrate_request
  localparam int ADCSEQ_CLK_LSB = 0;      // conversion_clock_select low bit
  localparam int ADCSEQ_ACQ_LSB = 3;      // acquisition_time_select low bit
  localparam int ADCSEQ_BIT_JUSTIFY = 7;  // result_justify_select
  localparam int ADCSEQ_BIT_DONE = 0;     // conversion_done_flag

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] ADCSEQ_RST_PIN_MASK = 16'hffff; // All pins analog
  localparam logic [3:0] ADCSEQ_RST_COMPARE = 4'h0;
  localparam logic [3:0] ADCSEQ_TRIG_MODE = 4'hb;         // Special-event code 1011

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam logic [4:0] ADCSEQ_CONV_TADS = 5'h0b;     // Bit periods per conversion
  localparam logic [4:0] ADCSEQ_RECOVER_TADS = 5'h02;  // Wait after completion/abort
  localparam logic [3:0] ADCSEQ_INSTR_CLKS = 4'h4;     // Oscillator clocks per instruction

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCSEQ_IDLE,
    ADCSEQ_DELAY,
    ADCSEQ_ACQ,
    ADCSEQ_CONV,
    ADCSEQ_RECOVER
  } adcseq_state_t;

endpackage

/* File: core/adcseq_top.sv */
/*
  Converter control sequencer: APB register file, bit-period generator,
  acquisition/conversion/recovery state machine, calibration and result
  formatting.
  Assumes the analog core settles sar_result_i by the last bit strobe of a
  conversion, that APB and special_event_i are on ref_clk_i, and that
  rc_clk_i and pin_level_i are asynchronous.
*/
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps

module adcseq_top
  import adcseq_pkg::*;
(
  input wire logic ref_clk_i,          // Oscillator clock
  input wire logic reset_n_i,          // Async reset, active low
  input wire logic psel_i,             // APB select
  input wire logic penable_i,          // APB enable
  input wire logic pwrite_i,           // APB write
  input wire logic [7:0] paddr_i,      // APB byte address
  input wire logic [31:0] pwdata_i,    // APB write data
  output logic [31:0] prdata_o,        // APB read data
  output logic pready_o,               // APB ready
  output logic pslverr_o,              // APB error, unmapped address
  input wire logic rc_clk_i,           // Internal RC oscillator, async
  input wire logic [15:0] pin_level_i, // Pin levels, async
  input wire logic special_event_i,    // Compare unit trigger pulse
  input wire logic [9:0] sar_result_i, // Analog core result
  output logic timer_clear_o,          // Clear compare timer, pulse
  output logic sample_en_o,            // Hold capacitor tracks input
  output logic cal_mode_o,             // Disconnect all channels
  output logic bit_strobe_o,           // One pulse per conversion period
  output logic [3:0] channel_o,        // Selected channel
  output logic busy_o                  // Start flag mirror
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Oscillator clocks per bit period for a clock select code
  function automatic logic [6:0] clk_ratio(input logic [2:0] sel);
    case (sel)
      3'h0: clk_ratio = 7'h02;
      3'h4: clk_ratio = 7'h04;
      3'h1: clk_ratio = 7'h08;
      3'h5: clk_ratio = 7'h10;
      3'h2: clk_ratio = 7'h20;
      3'h6: clk_ratio = 7'h40;
      default: clk_ratio = 7'h02; // RC codes do not use the divider
    endcase
  endfunction

  // Bit periods of acquisition for an acquisition select code
  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h7: acq_tads = 5'h14;
      3'h6: acq_tads = 5'h10;
      3'h5: acq_tads = 5'h0c;
      3'h4: acq_tads = 5'h08;
      3'h3: acq_tads = 5'h06;
      3'h2: acq_tads = 5'h04;
      3'h1: acq_tads = 5'h02;
      default: acq_tads = 5'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic on_reg, go_reg, cal_req_reg;       // Main control bits
  logic [3:0] chan_reg;                    // channel_select
  logic justify_reg;                       // result_justify_select
  logic [2:0] acqt_reg, adcs_reg;          // Timing selects
  logic [15:0] analog_mask_reg;            // One marks an analog pin
  logic [3:0] compare_mode_reg;            // compare_mode_select
  logic done_reg;                          // conversion_done_flag
  logic [7:0] res_hi_reg, res_lo_reg;      // Result pair, no reset
  logic [9:0] offset_reg;                  // Stored calibration offset
  logic cal_run_reg;                       // Current conversion is dummy
  adcseq_state_t state_reg, state_next;    // Sequencer state
  logic [5:0] div_cnt_reg;                 // Oscillator divider
  logic [4:0] tad_cnt_reg;                 // Bit periods in a phase
  logic [3:0] dly_cnt_reg;                 // Start delay counter
  logic rc_s1_reg, rc_s2_reg, rc_s3_reg;   // RC synchroniser and edge
  logic [15:0] pin_s1_reg, pin_s2_reg;     // Pin synchroniser
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg, timer_clear_reg;
  logic sample_en_reg, cal_mode_reg, bit_strobe_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup = psel_i & ~penable_i;             // Setup phase
  wire access = psel_i & penable_i & pready_reg; // Completing access edge
  wire wr = access & pwrite_i;
  wire hit_main = paddr_i == ADCSEQ_OFS_MAIN;
  wire hit_pin = paddr_i == ADCSEQ_OFS_PIN;
  wire hit_tim = paddr_i == ADCSEQ_OFS_TIMING;
  wire hit_hi = paddr_i == ADCSEQ_OFS_RES_HI;
  wire hit_lo = paddr_i == ADCSEQ_OFS_RES_LO;
  wire hit_stat = paddr_i == ADCSEQ_OFS_STATUS;
  wire hit_cmp = paddr_i == ADCSEQ_OFS_COMPARE;
  wire hit_port = paddr_i == ADCSEQ_OFS_PORT;
  wire mapped = hit_main | hit_pin | hit_tim | hit_hi | hit_lo | hit_stat | hit_cmp
    | hit_port;
  wire wr_main = wr & hit_main;
  wire wr_stat = wr & hit_stat;

  // Analog pins read low whatever their level
  wire [15:0] port_read = pin_s2_reg & ~analog_mask_reg;

  wire [31:0] rd_word =
    hit_main ? {24'h0, cal_req_reg, 1'b0, chan_reg, go_reg, on_reg} :
    hit_pin ? {16'h0, analog_mask_reg} :
    hit_tim ? {24'h0, justify_reg, 1'b0, acqt_reg, adcs_reg} :
    hit_hi ? {24'h0, res_hi_reg} :
    hit_lo ? {24'h0, res_lo_reg} :
    hit_stat ? {31'h0, done_reg} :
    hit_cmp ? {28'h0, compare_mode_reg} :
    hit_port ? {16'h0, port_read} : 32'h0;

  // ----------------------------------------------------------------
  // Bit-period generation
  // ----------------------------------------------------------------
  wire rc_sel = adcs_reg[1:0] == 2'h3;
  wire [6:0] ratio = clk_ratio(adcs_reg);
  wire div_tick = div_cnt_reg == 6'(ratio - 7'h01);
  wire rc_edge = rc_s2_reg & ~rc_s3_reg;
  wire running = state_reg == ADCSEQ_ACQ || state_reg == ADCSEQ_CONV
    || state_reg == ADCSEQ_RECOVER;
  wire tad_tick = running & (rc_sel ? rc_edge : div_tick);

  // ----------------------------------------------------------------
  // Sequencer decisions
  // ----------------------------------------------------------------
  wire acq_zero = acqt_reg == 3'h0;
  wire [4:0] acq_len = acq_tads(acqt_reg);
  // One instruction of delay each for zero acquisition and RC clock
  wire [3:0] dly_len = (acq_zero ? ADCSEQ_INSTR_CLKS : 4'h0)
    + (rc_sel ? ADCSEQ_INSTR_CLKS : 4'h0);
  wire phase_end_acq = tad_tick && tad_cnt_reg == 5'(acq_len - 5'h01);
  wire conv_last = tad_tick && tad_cnt_reg == ADCSEQ_CONV_TADS - 5'h01;
  wire done_evt = state_reg == ADCSEQ_CONV && go_reg && conv_last;
  wire trig_hit = special_event_i && compare_mode_reg == ADCSEQ_TRIG_MODE;
  wire trig_set = trig_hit && on_reg;
  // Pin direction plays no part in starting or running a conversion
  wire start = state_reg == ADCSEQ_IDLE && on_reg && go_reg;

  // Start flag: completion clears, event or software sets
  wire on_next = wr_main ? pwdata_i[ADCSEQ_BIT_ON] : on_reg;
  wire go_sw = wr_main ? pwdata_i[ADCSEQ_BIT_GO] : go_reg;
  wire go_next = !on_next ? 1'b0 : done_evt ? 1'b0
    : (trig_set | go_sw);
  // Hardware set wins over a software clear in the same cycle
  wire done_next = done_evt | (done_reg & ~(wr_stat & pwdata_i[ADCSEQ_BIT_DONE]));

  // Offset-compensated and justified result
  wire [9:0] corrected = sar_result_i >= offset_reg ? sar_result_i - offset_reg : 10'h0;
  wire [7:0] fmt_hi = justify_reg ? {6'h0, corrected[9:8]} : corrected[9:2];
  wire [7:0] fmt_lo = justify_reg ? corrected[7:0] : {corrected[1:0], 6'h0};
  wire store_res = done_evt && !cal_run_reg;

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ADCSEQ_IDLE: begin
        if (start) begin
          state_next = ADCSEQ_DELAY;
        end
      end
      ADCSEQ_DELAY: begin
        if (!go_reg) begin
          state_next = ADCSEQ_IDLE;
        end else if (dly_cnt_reg >= dly_len) begin
          state_next = acq_zero ? ADCSEQ_CONV : ADCSEQ_ACQ;
        end
      end
      ADCSEQ_ACQ: begin
        if (!go_reg) begin
          state_next = ADCSEQ_RECOVER;
        end else if (phase_end_acq) begin
          state_next = ADCSEQ_CONV;
        end
      end
      ADCSEQ_CONV: begin
        if (!go_reg || conv_last) begin
          state_next = ADCSEQ_RECOVER;
        end
      end
      ADCSEQ_RECOVER: begin
        if (tad_tick && tad_cnt_reg == ADCSEQ_RECOVER_TADS - 5'h01) begin
          state_next = ADCSEQ_IDLE;
        end
      end
      default: state_next = ADCSEQ_IDLE;
    endcase
    if (!on_reg) begin
      state_next = ADCSEQ_IDLE;
    end
  end

  wire phase_change = state_next != state_reg;
  // Divider restarts with every phase, so with a divided clock an abort from acquisition or conversion still waits two full periods
  wire [5:0] div_cnt_next = (!running || div_tick || phase_change) ? 6'h0
    : div_cnt_reg + 6'h1;
  wire [4:0] tad_cnt_next = phase_change ? 5'h0 : tad_cnt_reg + {4'h0, tad_tick};
  wire [3:0] dly_cnt_next = state_reg == ADCSEQ_DELAY ? dly_cnt_reg + 4'h1 : 4'h0;

  // ----------------------------------------------------------------
  // Control state, reset to off and idle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      on_reg <= 1'b0;
      go_reg <= 1'b0;
      cal_req_reg <= 1'b0;
      chan_reg <= 4'h0;
      justify_reg <= 1'b0;
      acqt_reg <= 3'h0;
      adcs_reg <= 3'h0;
      analog_mask_reg <= ADCSEQ_RST_PIN_MASK;
      compare_mode_reg <= ADCSEQ_RST_COMPARE;
      done_reg <= 1'b0;
      state_reg <= ADCSEQ_IDLE;
    end else begin
      on_reg <= on_next;
      go_reg <= go_next;
      cal_req_reg <= wr_main ? pwdata_i[ADCSEQ_BIT_CAL] : cal_req_reg;
      chan_reg <= wr_main ? pwdata_i[ADCSEQ_CHAN_LSB +: 4] : chan_reg;
      justify_reg <= (wr & hit_tim) ? pwdata_i[ADCSEQ_BIT_JUSTIFY] : justify_reg;
      acqt_reg <= (wr & hit_tim) ? pwdata_i[ADCSEQ_ACQ_LSB +: 3] : acqt_reg;
      adcs_reg <= (wr & hit_tim) ? pwdata_i[ADCSEQ_CLK_LSB +: 3] : adcs_reg;
      analog_mask_reg <= (wr & hit_pin) ? pwdata_i[15:0] : analog_mask_reg;
      compare_mode_reg <= (wr & hit_cmp) ? pwdata_i[3:0] : compare_mode_reg;
      done_reg <= done_next;
      state_reg <= state_next;
    end
  end

  // Counters, calibration and synchronisers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt_reg <= 6'h0;
      tad_cnt_reg <= 5'h0;
      dly_cnt_reg <= 4'h0;
      cal_run_reg <= 1'b0;
      offset_reg <= 10'h0;
      {rc_s1_reg, rc_s2_reg, rc_s3_reg} <= 3'h0;
      pin_s1_reg <= 16'h0;
      pin_s2_reg <= 16'h0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      tad_cnt_reg <= tad_cnt_next;
      dly_cnt_reg <= dly_cnt_next;
      cal_run_reg <= start ? cal_req_reg : cal_run_reg;
      offset_reg <= (done_evt && cal_run_reg) ? sar_result_i : offset_reg;
      {rc_s1_reg, rc_s2_reg, rc_s3_reg} <= {rc_clk_i, rc_s1_reg, rc_s2_reg};
      pin_s1_reg <= pin_level_i;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Result pair: not reset, so it holds across a reset
  always_ff @(posedge ref_clk_i) begin
    res_hi_reg <= store_res ? fmt_hi : (wr & hit_hi) ? pwdata_i[7:0] : res_hi_reg;
    res_lo_reg <= store_res ? fmt_lo : (wr & hit_lo) ? pwdata_i[7:0] : res_lo_reg;
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      timer_clear_reg <= 1'b0;
      sample_en_reg <= 1'b0;
      cal_mode_reg <= 1'b0;
      bit_strobe_reg <= 1'b0;
    end else begin
      // Answer one cycle after setup: one access cycle, no waits
      prdata_reg <= setup ? rd_word : prdata_reg;
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      timer_clear_reg <= trig_hit;
      // Sampling stops the moment conversion begins
      sample_en_reg <= on_next && (state_next == ADCSEQ_IDLE || state_next == ADCSEQ_DELAY
        || state_next == ADCSEQ_ACQ);
      cal_mode_reg <= state_next == ADCSEQ_CONV && (start ? cal_req_reg : cal_run_reg);
      bit_strobe_reg <= tad_tick && state_reg == ADCSEQ_CONV;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign timer_clear_o = timer_clear_reg;
  assign sample_en_o = sample_en_reg;
  assign cal_mode_o = cal_mode_reg;
  assign bit_strobe_o = bit_strobe_reg;
  assign channel_o = chan_reg;
  assign busy_o = go_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_conv_ends;
    state_reg == ADCSEQ_CONV && go_reg && conv_last;
  endsequence

  sequence s_done_seen;
    !go_reg && done_reg && state_reg == ADCSEQ_RECOVER;
  endsequence

  chk_conv_done: assert property (s_conv_ends |=> s_done_seen)
    else $error("completion did not clear start and set done");
  chk_conv_len: assert property (
    state_reg == ADCSEQ_CONV && state_next == ADCSEQ_RECOVER && go_reg
      |-> tad_cnt_reg == 5'h0a && tad_tick)
    else $error("conversion did not last eleven bit periods");
  chk_zero_acq: assert property (
    state_reg == ADCSEQ_DELAY && acq_zero && go_reg && state_next != ADCSEQ_DELAY
      |-> state_next == ADCSEQ_CONV && dly_cnt_reg >= ADCSEQ_INSTR_CLKS)
    else $error("zero acquisition did not go straight to conversion");
  chk_acq_len: assert property (
    state_reg == ADCSEQ_ACQ && state_next == ADCSEQ_CONV
      |-> tad_cnt_reg == 5'(acq_len - 5'h01) && tad_tick)
    else $error("acquisition length wrong");
  chk_abort_now: assert property (
    state_reg == ADCSEQ_CONV && !go_reg && on_reg
      |=> state_reg == ADCSEQ_RECOVER && $stable(res_hi_reg) && $stable(res_lo_reg))
    else $error("abort did not stop conversion or changed result");
  chk_recover_len: assert property (
    state_reg == ADCSEQ_RECOVER && state_next == ADCSEQ_IDLE && on_reg
      |-> tad_cnt_reg == 5'h01 && tad_tick)
    else $error("recovery wait not two bit periods");
  chk_trig_timer: assert property (trig_hit |=> timer_clear_o)
    else $error("event did not clear timer");
  chk_trig_off: assert property (
    trig_hit && !on_reg |=> !go_reg)
    else $error("event started a disabled converter");
  chk_port_zero: assert property (
    setup && hit_port |=> (prdata_o[15:0] & $past(analog_mask_reg)) == 16'h0)
    else $error("analog pin read nonzero");
  chk_reset_off: assert property (!on_reg |=> state_reg == ADCSEQ_IDLE)
    else $error("sequencer ran while off");

endmodule // adcseq_top

/* File: tb/adcseq_sar_model.sv */
/*
  Behavioural analog sample-and-hold and successive approximation core.
  Assumes the sequencer samples sar_result_i on the completing bit tick.
*/
`timescale 1ns/1ps
module adcseq_sar_model #(
  parameter logic [9:0] BASE_CODE = 10'h2a5,  // Code seen on channel 0
  parameter logic [9:0] OFFSET_CODE = 10'h013 // Code of the dummy conversion
) (
  input wire logic clk_i,          // Oscillator clock
  input wire logic sample_en_i,    // Hold capacitor tracking
  input wire logic cal_mode_i,     // All channels disconnected
  input wire logic [3:0] channel_i, // Selected channel
  output logic [9:0] sar_result_o  // Settled conversion code
);
  logic toggle_reg = 1'b0; // Flips every cycle
  // ----------------------------------------------------------------
  // Code output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    toggle_reg <= ~toggle_reg;
  end
  // While tracking no code is settled, so never repeat the last one
  assign sar_result_o = sample_en_i ? {5{toggle_reg, ~toggle_reg}} :
    cal_mode_i ? OFFSET_CODE : BASE_CODE + {6'h00, channel_i};
endmodule // adcseq_sar_model

/* File: tb/tb_adc_acquire_convert_sequencer.sv */
/*
  Self-checking bench for the converter sequencer.
  Assumes a single-access-cycle APB slave and the register map of the package.
*/
`timescale 1ns/1ps
module tb_adc_acquire_convert_sequencer;
  import adcseq_pkg::*;
  localparam logic [9:0] BASE = 10'h2a5; // Channel 0 code
  localparam logic [9:0] OFS = 10'h013;  // Dummy conversion code
  logic ref_clk_i = 0, reset_n_i = 0, rc_clk_i = 0, special_event_i = 0;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [15:0] pin_level_i = 16'h0000;
  logic [9:0] sar_result_i;
  logic [3:0] channel_o;
  logic pready_o, pslverr_o, timer_clear_o, sample_en_o, cal_mode_o, bit_strobe_o, busy_o, er;
  int num_errors = 0, samples_checked = 0, n, t_first, t_last, cal_seen;
  int ratio[6] = '{2, 4, 8, 16, 32, 64};
  logic [2:0] code[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  always #12.5 ref_clk_i = ~ref_clk_i; // 40 MHz
  always #137 rc_clk_i = ~rc_clk_i;    // Unrelated RC source
  adcseq_top i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rc_clk_i(rc_clk_i),
    .pin_level_i(pin_level_i), .special_event_i(special_event_i), .sar_result_i(sar_result_i),
    .timer_clear_o(timer_clear_o), .sample_en_o(sample_en_o), .cal_mode_o(cal_mode_o),
    .bit_strobe_o(bit_strobe_o), .channel_o(channel_o), .busy_o(busy_o));
  adcseq_sar_model #(.BASE_CODE(BASE), .OFFSET_CODE(OFS)) i_sar (.clk_i(ref_clk_i),
    .sample_en_i(sample_en_o), .cal_mode_i(cal_mode_o), .channel_i(channel_o),
    .sar_result_o(sar_result_i));
  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic fail(input string msg);
    num_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) fail(msg);
  endtask
  // One APB transfer; an idle cycle first keeps every drive single per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1;
    i = 0;
    do begin @(posedge ref_clk_i); i++; end while (pready_o !== 1'b1 && i < 20);
    rd = prdata_o; er = pslverr_o;
    psel_i <= 0; penable_i <= 0;
    if (pready_o !== 1'b1) begin fail("no ready"); end_of_test(); end
  endtask
  // Optional start write, then count bit strobes until busy drops; abort at stop_at
  task automatic convert(input logic wr, input logic [31:0] main, input int stop_at);
    int c, seen;
    if (wr) apb(1, ADCSEQ_OFS_MAIN, main);
    n = 0; seen = 0; cal_seen = 0;
    for (c = 0; c < 8000; c++) begin
      @(posedge ref_clk_i);
      if (bit_strobe_o === 1'b1) begin if (n == 0) t_first = c; t_last = c; n++; end
      if (cal_mode_o === 1'b1) cal_seen = 1;
      if (busy_o === 1'b1) seen = 1;
      if (stop_at > 0 && n == stop_at) begin apb(1, ADCSEQ_OFS_MAIN, main & ~32'h2); return; end
      if (seen && busy_o === 1'b0) break;
    end
    if (c >= 8000) begin fail("conversion hang"); end_of_test(); end
    repeat (3) @(posedge ref_clk_i) if (bit_strobe_o === 1'b1) n++;
  endtask
  task automatic check_res(input logic j, input logic [9:0] r);
    apb(0, ADCSEQ_OFS_RES_HI, 0);
    check(rd, j ? {30'h0, r[9:8]} : {24'h0, r[9:2]}, "result high");
    apb(0, ADCSEQ_OFS_RES_LO, 0);
    check(rd, j ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h00}, "result low");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    apb(0, ADCSEQ_OFS_PIN, 0);
    check(rd, {16'h0, ADCSEQ_RST_PIN_MASK}, "pin mask reset");
    apb(0, 8'h20, 0);
    check({er, rd[30:0]}, 32'h80000000, "unmapped access");
    pin_level_i <= 16'h5aa5;
    apb(1, ADCSEQ_OFS_PIN, 32'h0ff0);
    repeat (4) @(posedge ref_clk_i);
    apb(0, ADCSEQ_OFS_PORT, 0);
    check(rd, 32'h5005, "analog pins read low");
    $display("Registers done");
  endtask
  task automatic test_clocks();
    apb(1, ADCSEQ_OFS_MAIN, 32'h01);
    apb(1, ADCSEQ_OFS_TIMING, 32'h10);
    convert(1, 32'h83, 0);
    check(cal_seen, 1, "no dummy conversion");
    apb(1, ADCSEQ_OFS_STATUS, 32'h1);
    for (int k = 0; k < 6; k++) begin
      // The model has no minimum bit period, so every ratio is legal
      apb(1, ADCSEQ_OFS_TIMING, {24'h0, k[0], 4'h2, code[k]});
      convert(1, 32'h03 | (k << 2), 0);
      check(n, 11, "strobe count");
      check(t_last - t_first, 10 * ratio[k], "bit period");
      check(cal_seen, 0, "dummy conversion repeated");
      check(channel_o, k, "channel select");
      apb(0, ADCSEQ_OFS_STATUS, 0);
      check(rd, 32'h1, "done flag");
      check_res(k[0], BASE + k[9:0] - OFS);
      apb(1, ADCSEQ_OFS_STATUS, 32'h1);
    end
    // Zero acquisition: select the channel first, then wait before starting
    apb(1, ADCSEQ_OFS_MAIN, 32'h01);
    repeat (100) @(posedge ref_clk_i);
    apb(1, ADCSEQ_OFS_TIMING, 32'h83);
    convert(1, 32'h03, 0);
    check(n, 11, "strobe count rc");
    $display("Clock selection done");
  endtask
  task automatic test_abort();
    apb(1, ADCSEQ_OFS_STATUS, 32'h1);
    apb(1, ADCSEQ_OFS_TIMING, 32'h10);
    convert(1, 32'h0b, 3);
    repeat (40) @(posedge ref_clk_i);
    apb(0, ADCSEQ_OFS_STATUS, 0);
    check(rd, 32'h0, "abort sets done");
    check_res(1'b1, BASE - OFS);
    check(sample_en_o, 1, "no resampling");
    $display("Abort done");
  endtask
  task automatic test_event();
    apb(1, ADCSEQ_OFS_COMPARE, {28'h0, ADCSEQ_TRIG_MODE});
    for (int on = 1; on >= 0; on--) begin
      apb(1, ADCSEQ_OFS_MAIN, on);
      special_event_i <= 1;
      @(posedge ref_clk_i) special_event_i <= 0;
      @(posedge ref_clk_i);
      check(timer_clear_o, 1, "timer clear");
      n = 0;
      if (on) convert(0, 0, 0);
      else repeat (20) @(posedge ref_clk_i) if (bit_strobe_o === 1'b1) n++;
      check(n, 11 * on, "event conversion");
      check(busy_o, 0, "busy after event");
    end
    $display("Special event done");
  endtask
  // Reset in mid-conversion: converter off, result pair untouched
  task automatic test_reset();
    apb(1, ADCSEQ_OFS_MAIN, 32'h01);
    apb(1, ADCSEQ_OFS_MAIN, 32'h03);
    n = 0;
    for (int c = 0; c < 400 && n < 2; c++) begin
      @(posedge ref_clk_i);
      if (bit_strobe_o === 1'b1) n++;
    end
    check(n, 2, "no conversion before reset");
    reset_n_i <= 0;
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1;
    check({busy_o, sample_en_o, bit_strobe_o}, 32'h0, "converter ran through reset");
    apb(0, ADCSEQ_OFS_MAIN, 0);
    check(rd, 32'h0, "converter on after reset");
    check_res(1'b0, BASE - OFS);
    $display("Reset done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1;
    test_regs();
    test_clocks();
    test_abort();
    test_event();
    test_reset();
    end_of_test();
  end
endmodule // tb_adc_acquire_convert_sequencer
